/* remote_io_status_map.sv */
`timescale 1ns/100ps
`default_nettype none
module remote_io_status_map
  import remote_io_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        twelve_axis_mode,
  input  wire logic        three_wire_mode,
  input  wire logic        comm_enable_setting,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        fault_output_one,
  input  wire logic        warning_flag,
  input  wire logic        torque_limit_hit,
  input  wire logic        speed_reached,
  input  wire logic        motion_active,
  input  wire logic        fault_output_two,
  input  wire logic        serial_link_busy,
  input  wire logic        serial_rate_error,
  input  wire logic        serial_addr_error,
  input  wire logic        fieldbus_error,
  input  wire logic        serial_fault_clear,
  input  wire logic        fieldbus_fault_clear,
  output logic [2:0]       data_select,
  output logic             clockwise_run_cmd,
  output logic             counterclockwise_run_cmd,
  output logic             halt_style,
  output logic             brake_release_cmd,
  output logic             three_wire_start_stop,
  output logic             three_wire_spin_halt,
  output logic             three_wire_direction,
  output logic [15:0]      status_out,
  output logic [1:0]       status_len_bytes,
  output logic             comm_enabled,
  output logic             link_bit_tick,
  output logic             serial_link_fault_led,
  output logic             fieldbus_fault_led
);
  // ==========================================================
  // Power-up capture of the communication enable
  logic       en_loaded_q, en_loaded_d;
  logic       comm_en_q, comm_en_d;

  always_comb begin
    en_loaded_d = 1'b1;
    comm_en_d   = en_loaded_q ? comm_en_q : comm_enable_setting;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_loaded_q <= 1'b0;
      comm_en_q   <= 1'b0;
    end else begin
      en_loaded_q <= en_loaded_d;
      comm_en_q   <= comm_en_d;
    end
  end

  assign comm_enabled = comm_en_q;

  // ==========================================================
  // Command latch and decode
  logic [7:0] cmd_q, cmd_d;
  logic       accept;

  assign accept = cmd_valid && comm_en_q && en_loaded_q;

  always_comb begin
    cmd_d = cmd_q;
    if (accept) begin
      cmd_d = cmd_byte;
      cmd_d[6] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= CMD_RESET;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  assign data_select              = cmd_q[CMD_DS_LSB +: 3];
  assign brake_release_cmd        = cmd_q[CMD_BRAKE];
  assign clockwise_run_cmd        = !three_wire_mode && cmd_q[CMD_CW];
  assign counterclockwise_run_cmd = !three_wire_mode && cmd_q[CMD_CCW];
  assign halt_style               = !three_wire_mode && cmd_q[CMD_HALT];
  assign three_wire_start_stop    = three_wire_mode && cmd_q[CMD_CW];
  assign three_wire_spin_halt     = three_wire_mode && cmd_q[CMD_CCW];
  assign three_wire_direction     = three_wire_mode && cmd_q[CMD_HALT];

  // ==========================================================
  // Status word register
  logic [15:0] status_comb;
  logic [15:0] status_q, status_d;
  logic [1:0]  len_q, len_d;

  status_word_pack u_pack (
    .twelve_axis_mode (twelve_axis_mode),
    .cmd_latched      (cmd_q),
    .fault_output_one (fault_output_one),
    .warning_flag     (warning_flag),
    .torque_limit_hit (torque_limit_hit),
    .speed_reached    (speed_reached),
    .motion_active    (motion_active),
    .fault_output_two (fault_output_two),
    .serial_link_busy (serial_link_busy),
    .status_word      (status_comb)
  );

  always_comb begin
    status_d = status_comb;
    len_d    = twelve_axis_mode ? LEN_TWELVE : LEN_SIX;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= STATUS_RESET;
      len_q    <= LEN_SIX;
    end else begin
      status_q <= status_d;
      len_q    <= len_d;
    end
  end

  assign status_out       = status_q;
  assign status_len_bytes = len_q;

  // ==========================================================
  // Link bit-rate enable
  logic [7:0] bit_cnt_q, bit_cnt_d;
  logic       tick_q, tick_d;

  always_comb begin
    tick_d    = (bit_cnt_q == BIT_CNT_LAST);
    bit_cnt_d = tick_d ? 8'h00 : bit_cnt_q + 8'h01;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_q <= 8'h00;
      tick_q    <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      tick_q    <= tick_d;
    end
  end

  assign link_bit_tick = tick_q;

  // ==========================================================
  // Fault lamps, set wins over clear
  logic ser_led_q, ser_led_d;
  logic fb_led_q, fb_led_d;
  logic ser_err;

  assign ser_err = serial_rate_error || serial_addr_error;

  always_comb begin
    ser_led_d = ser_err || (ser_led_q && !serial_fault_clear);
    fb_led_d  = fieldbus_error || (fb_led_q && !fieldbus_fault_clear);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ser_led_q <= 1'b0;
      fb_led_q  <= 1'b0;
    end else begin
      ser_led_q <= ser_led_d;
      fb_led_q  <= fb_led_d;
    end
  end

  assign serial_link_fault_led = ser_led_q;
  assign fieldbus_fault_led    = fb_led_q;

  // ==========================================================
  // Assertions
  sequence s_cmd_taken;
    cmd_valid && comm_en_q && en_loaded_q;
  endsequence

  sequence s_echo_seen;
    ##1 status_out[ST_CW_ECHO +: 3] == $past(cmd_byte[CMD_CW +: 3], 2);
  endsequence

  property p_echo_follows_cmd;
    @(posedge clk) disable iff (!rstn)
      s_cmd_taken ##1 !cmd_valid |-> ##1 status_out[ST_DS_LSB +: 3] == $past(cmd_byte[2:0], 2);
  endproperty
  a_echo_follows_cmd: assert property (p_echo_follows_cmd) else $error("select echo wrong");

  property p_three_wire_echo;
    @(posedge clk) disable iff (!rstn)
      s_cmd_taken ##1 !cmd_valid |-> s_echo_seen;
  endproperty
  a_three_wire_echo: assert property (p_three_wire_echo) else $error("run echo wrong");

  property p_twelve_no_high;
    @(posedge clk) disable iff (!rstn)
      twelve_axis_mode |=> status_out[15:8] == 8'h00 && status_len_bytes == LEN_TWELVE;
  endproperty
  a_twelve_no_high: assert property (p_twelve_no_high) else $error("high byte in twelve mode");

  property p_busy_six;
    @(posedge clk) disable iff (!rstn)
      !twelve_axis_mode |=> status_out[ST_BUSY] == $past(serial_link_busy)
        && status_len_bytes == LEN_SIX;
  endproperty
  a_busy_six: assert property (p_busy_six) else $error("busy bit wrong");

  property p_unused_zero;
    @(posedge clk) disable iff (!rstn)
      status_out[11:9] == 3'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused status bit set");

  property p_decode_split;
    @(posedge clk) disable iff (!rstn)
      three_wire_mode |-> !clockwise_run_cmd && three_wire_start_stop == cmd_q[CMD_CW];
  endproperty
  a_decode_split: assert property (p_decode_split) else $error("three-wire decode wrong");

  property p_tick_period;
    @(posedge clk) disable iff (!rstn)
      link_bit_tick |=> !link_bit_tick [*8] ##[192:192] link_bit_tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("bit tick period wrong");

  property p_enable_frozen;
    @(posedge clk) disable iff (!rstn)
      en_loaded_q |=> $stable(comm_enabled);
  endproperty
  a_enable_frozen: assert property (p_enable_frozen) else $error("enable changed live");

  property p_serial_led;
    @(posedge clk) disable iff (!rstn)
      serial_rate_error || serial_addr_error |=> serial_link_fault_led;
  endproperty
  a_serial_led: assert property (p_serial_led) else $error("serial lamp not lit");

  property p_fieldbus_led;
    @(posedge clk) disable iff (!rstn)
      fieldbus_error && !serial_link_fault_led && !serial_rate_error && !serial_addr_error
        |=> fieldbus_fault_led && !serial_link_fault_led;
  endproperty
  a_fieldbus_led: assert property (p_fieldbus_led) else $error("fieldbus lamp wrong");
endmodule // remote_io_status_map
`default_nettype wire

/* remote_io_pkg.sv */
// Overview of operation
// - Six-axis status word: low byte echoes and flags, high byte limit, speed, motion, second fault, busy.
// - Twelve-axis mode returns only the low status byte, high byte not sent.
// - Three-wire mode reassigns echoes: start-stop, three_wire_spin_halt, direction.
// - Command byte: select 0-2, cw 3, ccw 4, halt 5, brake 7; three-wire reuses 3-5.
// - Serial link runs at 625,000 bps on both ends.
// - Default frame: 16 bit I/O per axis, 32 byte transmission length.
// - Communication enable setting takes effect only after the next power cycle.
// - Serial link fault lamp lights on RS-485 communication error.
// - Fieldbus fault lamp lights on fieldbus error, separate from serial faults.
`default_nettype none
package remote_io_pkg;
  // ==========================================================
  // Command byte layout
  localparam int CMD_DS_LSB      = 0;
  localparam int CMD_CW          = 3;
  localparam int CMD_CCW         = 4;
  localparam int CMD_HALT        = 5;
  localparam int CMD_BRAKE       = 7;
  // ==========================================================
  // Status word layout
  localparam int ST_DS_LSB       = 0;
  localparam int ST_CW_ECHO      = 3;
  localparam int ST_CCW_ECHO     = 4;
  localparam int ST_HALT_ECHO    = 5;
  localparam int ST_WARN         = 6;
  localparam int ST_FAULT1       = 7;
  localparam int ST_BUSY         = 8;
  localparam int ST_FAULT2       = 12;
  localparam int ST_MOVE         = 13;
  localparam int ST_SPEED        = 14;
  localparam int ST_TORQUE       = 15;
  // ==========================================================
  // Frame sizing and codes
  localparam int IO_BITS_PER_AXIS = 16;
  localparam int FRAME_BYTES      = 32;
  localparam logic [1:0] LEN_SIX  = 2'h2;
  localparam logic [1:0] LEN_TWELVE = 2'h1;
  localparam logic [7:0] ASYNC_IO_CODE_GEN2 = 8'h50;
  localparam logic [7:0] ASYNC_IO_CODE_GEN3 = 8'h20;
  // ==========================================================
  // Timing
  localparam longint CLK_HZ       = 125000000;
  localparam longint LINK_BPS     = 625000;
  localparam int BIT_CYCLES       = int'(CLK_HZ / LINK_BPS);
  localparam logic [7:0] BIT_CNT_LAST = 8'(BIT_CYCLES - 1);
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [7:0] CMD_RESET    = 8'h00;
endpackage : remote_io_pkg
`default_nettype wire

/* status_word_pack.sv */
`timescale 1ns/100ps
`default_nettype none
module status_word_pack
  import remote_io_pkg::*;
(
  input  wire logic        twelve_axis_mode,
  input  wire logic [7:0]  cmd_latched,
  input  wire logic        fault_output_one,
  input  wire logic        warning_flag,
  input  wire logic        torque_limit_hit,
  input  wire logic        speed_reached,
  input  wire logic        motion_active,
  input  wire logic        fault_output_two,
  input  wire logic        serial_link_busy,
  output logic      [15:0] status_word
);
  always_comb begin
    status_word = STATUS_RESET;
    status_word[ST_DS_LSB +: 3]  = cmd_latched[CMD_DS_LSB +: 3];
    // Same bit slots carry start-stop, three_wire_spin_halt and direction in three-wire mode
    status_word[ST_CW_ECHO]   = cmd_latched[CMD_CW];
    status_word[ST_CCW_ECHO]  = cmd_latched[CMD_CCW];
    status_word[ST_HALT_ECHO] = cmd_latched[CMD_HALT];
    status_word[ST_WARN]      = warning_flag;
    status_word[ST_FAULT1]    = fault_output_one;
    if (!twelve_axis_mode) begin
      status_word[ST_BUSY]    = serial_link_busy;
      status_word[ST_FAULT2]  = fault_output_two;
      status_word[ST_MOVE]    = motion_active;
      status_word[ST_SPEED]   = speed_reached;
      status_word[ST_TORQUE]  = torque_limit_hit;
    end
  end
endmodule // status_word_pack
`default_nettype wire

/* fieldbus_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fieldbus_host_model
  import remote_io_pkg::*;
(
  input  wire logic       clk,
  output var  logic       cmd_valid,
  output var  logic [7:0] cmd_byte
);
  // ==========================================================
  // Asynchronous remote I/O update
  initial begin
    cmd_valid = 1'b0;
    cmd_byte  = 8'h00;
  end

  // Only the async update codes reach the axis; more keeps valid up for back to back
  task automatic async_update(input logic [7:0] code, input logic [7:0] data, input logic more);
    if (code === ASYNC_IO_CODE_GEN2 || code === ASYNC_IO_CODE_GEN3) begin
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_byte  = data;
      if (!more) begin
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_byte  = ~data;
      end
    end
  endtask
endmodule // fieldbus_host_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb
  import remote_io_pkg::*;
;
  typedef struct packed {
    logic        twelve;
    logic        three;
    logic [7:0]  code;
    logic [7:0]  cmd;
    logic [6:0]  st;
    logic [15:0] exp;
  } row_t;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        twelve_axis_mode = 1'b0;
  logic        three_wire_mode = 1'b0;
  logic        comm_enable_setting = 1'b0;
  logic [6:0]  st = 7'h00;
  logic [4:0]  err = 5'h00;
  wire  logic  cmd_valid;
  wire  logic [7:0] cmd_byte;
  wire  logic [9:0] dec;
  wire  logic [1:0] leds;
  wire  logic [15:0] status_out;
  wire  logic [1:0] status_len_bytes;
  wire  logic  comm_enabled;
  wire  logic  link_bit_tick;
  int          errors = 0;
  int          compares = 0;
  int          n;
  row_t        rows [6] = '{
    '{1'b0, 1'b0, ASYNC_IO_CODE_GEN2, 8'h08, 7'h00, 16'h0008},
    '{1'b0, 1'b0, ASYNC_IO_CODE_GEN3, 8'hFF, 7'h7F, 16'hF1FF},
    '{1'b1, 1'b0, ASYNC_IO_CODE_GEN2, 8'h15, 7'h7F, 16'h00D5},
    '{1'b0, 1'b1, ASYNC_IO_CODE_GEN3, 8'h28, 7'h10, 16'h8028},
    '{1'b0, 1'b0, ASYNC_IO_CODE_GEN2, 8'h40, 7'h01, 16'h0100},
    '{1'b1, 1'b1, ASYNC_IO_CODE_GEN3, 8'h90, 7'h40, 16'h0090}};

  always #4 clk = ~clk;

  fieldbus_host_model i_host (.clk, .cmd_valid, .cmd_byte);

  remote_io_status_map i_dut (
    .clk, .rstn, .twelve_axis_mode, .three_wire_mode, .comm_enable_setting, .cmd_valid, .cmd_byte,
    .fault_output_one(st[6]), .warning_flag(st[5]), .torque_limit_hit(st[4]), .speed_reached(st[3]),
    .motion_active(st[2]), .fault_output_two(st[1]), .serial_link_busy(st[0]),
    .serial_rate_error(err[4]), .serial_addr_error(err[3]), .fieldbus_error(err[2]),
    .serial_fault_clear(err[1]), .fieldbus_fault_clear(err[0]),
    .data_select(dec[9:7]), .clockwise_run_cmd(dec[6]), .counterclockwise_run_cmd(dec[5]),
    .halt_style(dec[4]), .brake_release_cmd(dec[3]), .three_wire_start_stop(dec[2]),
    .three_wire_spin_halt(dec[1]), .three_wire_direction(dec[0]), .status_out, .status_len_bytes,
    .comm_enabled, .link_bit_tick, .serial_link_fault_led(leds[1]), .fieldbus_fault_led(leds[0]));

  // ==========================================================
  // Checking helpers
  function automatic logic [9:0] dec_exp(input logic three, input logic [7:0] c);
    dec_exp = {c[2:0], !three & c[3], !three & c[4], !three & c[5], c[7], three & c[3], three & c[4], three & c[5]};
  endfunction

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  task automatic lamp(input logic [4:0] e, input logic [1:0] x);
    err = e;
    @(negedge clk);
    chk("lamps", 16'(leds), 16'(x));
  endtask

  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_of_test();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (2) @(negedge clk);
    chk("reset_outputs", {dec, leds, comm_enabled, link_bit_tick, status_len_bytes}, 16'h0002);
    chk("reset_status", status_out, 16'h0000);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    i_host.async_update(ASYNC_IO_CODE_GEN2, 8'h08, 1'b0);
    chk("refused", {dec, 5'h00, comm_enabled}, 16'h0000);
    comm_enable_setting = 1'b1;
    i_host.async_update(ASYNC_IO_CODE_GEN2, 8'h08, 1'b0);
    chk("late_enable", {dec, 5'h00, comm_enabled}, 16'h0000);
    do_reset();
    chk("enabled", 16'(comm_enabled), 16'h0001);
    $display("reset and enable done");
    foreach (rows[i]) begin
      twelve_axis_mode = rows[i].twelve;
      three_wire_mode = rows[i].three;
      st = rows[i].st;
      i_host.async_update(rows[i].code, rows[i].cmd, 1'b0);
      chk("decode", 16'(dec), 16'(dec_exp(rows[i].three, rows[i].cmd)));
      chk("length", 16'(status_len_bytes), rows[i].twelve ? 16'h0001 : 16'h0002);
      @(negedge clk);
      chk("status", status_out, rows[i].exp);
    end
    $display("table done");
    twelve_axis_mode = 1'b0;
    three_wire_mode = 1'b0;
    st = 7'h00;
    i_host.async_update(ASYNC_IO_CODE_GEN3, 8'h08, 1'b1);
    i_host.async_update(ASYNC_IO_CODE_GEN3, 8'h10, 1'b0);
    chk("last_wins", 16'(dec), 16'(dec_exp(1'b0, 8'h10)));
    @(negedge clk);
    chk("last_echo", status_out, 16'h0010);
    $display("back to back done");
    lamp(5'b01000, 2'b10);
    lamp(5'b00000, 2'b10);
    lamp(5'b00010, 2'b00);
    lamp(5'b10000, 2'b10);
    lamp(5'b10010, 2'b10);
    lamp(5'b00100, 2'b11);
    lamp(5'b00010, 2'b01);
    lamp(5'b00001, 2'b00);
    lamp(5'b00100, 2'b01);
    lamp(5'b00001, 2'b00);
    lamp(5'b00000, 2'b00);
    $display("lamps done");
    n = 0;
    while (link_bit_tick !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    @(negedge clk);
    while (link_bit_tick !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk("tick_gap", 16'(n + 1), 16'h00C8);
    $display("bit tick done");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
